/* src/boot_loader_defines.svh */
// Purpose: Constants of the power-up boot loader.
// Assumes: Included by bare name from the design files.
// Notes:   Wait-state and strap sync counts are in core clock cycles at 100 MHz; other counts are words, bytes or nibbles.
`ifndef BOOT_LOADER_DEFINES_SVH
`define BOOT_LOADER_DEFINES_SVH
`define BOOT_KERNEL_WORDS     9'h100
`define EPROM_BYTE_COUNT      12'h600
`define EPROM_EXT_BASE        24'h800000
`define BOOT_INT_BASE         24'h040000
`define BOOT_INT_LAST         24'h0400ff
`define BOOT_DONE_VECTOR      24'h040050
`define EPROM_WAIT_STATES     3'h7
`define WORD_NIBBLES          4'hc
`define DMA_CH_EXT_PORT       4'ha
`define DMA_CH_SPI            4'h8
`define DMA_CH_LINK           4'h4
`define LINK_BOOT_BUFFER      3'h4
`define STRAP_SYNC_CYCLES     2'h3
`endif

/* src/boot_loader_pkg.sv */
// Purpose: Types shared by the boot loader modules.
// Assumes: Nothing beyond the defines header.
// Notes:   Enums carry no explicit codes.
package boot_loader_pkg;
   typedef enum logic [2:0] {BT_NONE, BT_EPROM, BT_HOST, BT_LINK, BT_SPI} boot_type_t;
   typedef enum logic [1:0] {ST_SAMPLE, ST_LOAD, ST_FLUSH, ST_RUN} loader_state_t;
endpackage

/* src/boot_word_buffer.sv */
// Purpose: Two-entry valid/ready buffer between the packer and internal memory.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Outputs come straight from flip-flops.
`timescale 1ns/10ps
module boot_word_buffer #(
   parameter int W = 72
) (
   input  wire logic         mclk,      // Core clock.
   input  wire logic         nrst,      // Asynchronous reset, active low.
   input  wire logic         in_valid,  // Word offered.
   output logic              in_ready,  // Room for a word.
   input  wire logic [W-1:0] in_data,   // Offered word.
   output logic              out_valid, // Head entry holds a word.
   input  wire logic         out_ready, // Sink takes the head.
   output logic [W-1:0]      out_data   // Head word.
);
   logic [W-1:0] head_q, tail_q;
   logic         vld_q, full_q, push, pop;

   assign push      = in_valid && !full_q;
   assign pop       = vld_q && out_ready;
   assign in_ready  = !full_q;
   assign out_valid = vld_q;
   assign out_data  = head_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         vld_q  <= 1'b0;
         full_q <= 1'b0;
      end else begin
         vld_q  <= push || (vld_q && !(pop && !full_q));
         full_q <= push && !pop && vld_q || (full_q && !pop) || (full_q && push);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         head_q <= '0;
         tail_q <= '0;
      end else begin
         if (pop) begin
            head_q <= full_q ? tail_q : in_data;
         end else if (push && !vld_q) begin
            head_q <= in_data;
         end
         if (push && (full_q || (vld_q && !pop))) begin
            tail_q <= in_data;
         end
      end
   end
endmodule

/* src/power_up_boot_mode_loader.sv */
// Purpose: Selects the boot type from straps and loads the 256-word boot kernel.
// Assumes: Host, link and SPI ports hand over units on the core clock.
// Notes:   Strap and EPROM data pins are synchronised before use.
//
// Overview of operation
// - EPROM strap high, link low: EPROM boot
// - Both straps low, select high: host boot
// - EPROM low, link high, select high: link boot
// - EPROM low, link high, select low: SPI, channel 8
// - All low: no load, run external memory
// - Select pin is input unless EPROM mode
// - EPROM select three-statable, bus master only
// - EPROM boot reads 8-bit bytes
// - Host boot takes 8- or 16-bit units
// - Link boot takes nibbles into buffer 4
// - SPI bytes captured in receive register first
// - Channel set up for exactly 256 words
// - Load every reset; run after transfer
// - Words land at 0x40000 through 0x400ff
// - Pack units least significant first, 48 bits
// - Address from 0x800000, seven wait states
// - Counters zero: stop, interrupt, release, vector
`timescale 1ns/10ps
`include "boot_loader_defines.svh"
module power_up_boot_mode_loader
   import boot_loader_pkg::*;
#(
   parameter logic [23:0] NOBOOT_VECTOR = 24'h200000  // External start address in no-boot mode.
) (
   input  wire logic        mclk,                     // Core clock, 100 MHz.
   input  wire logic        nrst,                     // Chip reset, active low.
   input  wire logic        eprom_boot_strap,         // Strap pin.
   input  wire logic        link_boot_strap,          // Strap pin.
   input  wire logic        host_bus_16bit,           // Host width strap pin, high for 16 bits.
   input  wire logic        boot_memory_select_in,    // Select pin input level.
   output logic             boot_memory_select_out,   // Select pin drive, low selects EPROM.
   output logic             boot_memory_select_oe_n,  // Low while the pin is driven.
   input  wire logic        bus_master,               // This device owns the external bus.
   output logic [23:0]      ext_addr,                 // EPROM byte address.
   output logic             ext_rd_n,                 // EPROM read strobe, active low.
   input  wire logic [7:0]  ext_data,                 // EPROM data pins.
   input  wire logic        host_valid,               // Host unit offered.
   input  wire logic [15:0] host_data,                // Host unit.
   output logic             host_ready,               // Host unit taken when valid.
   input  wire logic        link_valid,               // Link nibble offered.
   input  wire logic [3:0]  link_nibble,              // Link nibble.
   output logic             link_ready,               // Link nibble taken when valid.
   output logic [2:0]       link_rx_buffer,           // Link buffer receiving boot data.
   input  wire logic        spi_rx_valid,             // SPI byte offered.
   input  wire logic [7:0]  spi_rx_byte,              // SPI byte.
   output logic             spi_rx_ready,             // SPI byte taken when valid.
   output logic             mem_wr_valid,             // Internal memory write.
   output logic [23:0]      mem_wr_addr,              // Internal word address.
   output logic [47:0]      mem_wr_data,              // Instruction word.
   input  wire logic        mem_wr_ready,             // Memory accepts the write.
   output boot_type_t       boot_type,                // Decoded boot type.
   output logic [3:0]       dma_channel,              // Channel carrying the load.
   output logic             boot_dma_done_interrupt,  // One-cycle completion pulse.
   output logic             core_start,               // Core may fetch, level.
   output logic [23:0]      core_start_vector         // First fetch address.
);
   // ****************************************************************
   // Pin synchronisers and strap sampling
   // ****************************************************************
   logic [11:0]   pin_s1_q, pin_s2_q;
   logic [1:0]    samp_cnt_q;
   loader_state_t state_q;
   boot_type_t    type_q;
   logic          wide_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= {host_bus_16bit, boot_memory_select_in, link_boot_strap, eprom_boot_strap, ext_data};
         pin_s2_q <= pin_s1_q;
      end
   end

   function automatic boot_type_t decode_straps(input logic eb, input logic lb, input logic sel);
      if (eb) begin
         decode_straps = lb ? BT_NONE : BT_EPROM;
      end else if (sel) begin
         decode_straps = lb ? BT_LINK : BT_HOST;
      end else begin
         decode_straps = lb ? BT_SPI : BT_NONE;
      end
   endfunction

   // Nibbles per unit for each source width.
   function automatic logic [3:0] unit_nibbles(input boot_type_t t, input logic wide);
      case (t)
         BT_LINK: unit_nibbles = 4'h1;
         BT_HOST: unit_nibbles = wide ? 4'h4 : 4'h2;
         default: unit_nibbles = 4'h2;
      endcase
   endfunction

   // Waiting for the synchroniser to fill keeps stale reset levels out of the decode.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         samp_cnt_q <= '0;
         type_q     <= BT_NONE;
         wide_q     <= 1'b0;
      end else if (state_q == ST_SAMPLE) begin
         samp_cnt_q <= samp_cnt_q + 2'h1;
         if (samp_cnt_q == `STRAP_SYNC_CYCLES - 2'h1) begin
            type_q <= decode_straps(pin_s2_q[8], pin_s2_q[9], pin_s2_q[10]);
            wide_q <= pin_s2_q[11];
         end
      end
   end

   // ****************************************************************
   // Unit sources and packing
   // ****************************************************************
   logic        pend_q, spi_full_q, rd_active_q, take, push, buf_ready, more;
   logic [2:0]  rd_cnt_q;
   logic [7:0]  spi_receive_data_q;
   logic [3:0]  pos_q, step;
   logic [15:0] unit;
   logic [47:0] acc_q;
   logic [8:0]  words_q;
   logic [11:0] ext_cnt_q;
   logic [23:0] int_addr_q, ext_addr_q;
   logic        rd_last, pend_d;

   assign step    = unit_nibbles(type_q, wide_q);
   assign rd_last = rd_active_q && rd_cnt_q == `EPROM_WAIT_STATES;
   assign push    = pend_q && buf_ready;
   assign more    = words_q != 9'h0 && !(push && words_q == 9'h1);

   always_comb begin
      take = 1'b0;
      unit = '0;
      if (state_q == ST_LOAD && !pend_q) begin
         case (type_q)
            BT_EPROM: begin
               take = rd_last;
               unit = {8'h0, pin_s2_q[7:0]};
            end
            BT_HOST: begin
               take = host_valid && host_ready;
               unit = wide_q ? host_data : {8'h0, host_data[7:0]};
            end
            BT_LINK: begin
               take = link_valid && link_ready;
               unit = {12'h0, link_nibble};
            end
            BT_SPI: begin
               take = spi_full_q;
               unit = {8'h0, spi_receive_data_q};
            end
            default: begin
               take = 1'b0;
            end
         endcase
      end
   end

   assign pend_d = (pend_q && !push) || (take && pos_q + step == `WORD_NIBBLES);

   genvar g;
   generate
      for (g = 0; g < 12; g++) begin : g_lane
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               acc_q[g*4 +: 4] <= 4'h0;
            end else if (take && g >= pos_q && g < pos_q + step) begin
               acc_q[g*4 +: 4] <= unit[(4'(g) - pos_q)*4 +: 4];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pos_q  <= '0;
         pend_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
         if (take) begin
            pos_q <= (pos_q + step == `WORD_NIBBLES) ? 4'h0 : pos_q + step;
         end
      end
   end

   // Ready outputs are registered, so the next cycle's hold-off is decided here.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         host_ready   <= 1'b0;
         link_ready   <= 1'b0;
         spi_rx_ready <= 1'b0;
      end else begin
         host_ready   <= state_q == ST_LOAD && type_q == BT_HOST && !pend_d && more;
         link_ready   <= state_q == ST_LOAD && type_q == BT_LINK && !pend_d && more;
         spi_rx_ready <= state_q == ST_LOAD && type_q == BT_SPI && !pend_d && more && !(spi_full_q && !take)
                         && !(spi_rx_valid && spi_rx_ready);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         spi_full_q         <= 1'b0;
         spi_receive_data_q <= '0;
      end else if (spi_rx_valid && spi_rx_ready) begin
         spi_full_q         <= 1'b1;
         spi_receive_data_q <= spi_rx_byte;
      end else if (take) begin
         spi_full_q <= 1'b0;
      end
   end

   // ****************************************************************
   // EPROM strobe sequencer
   // ****************************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rd_active_q <= 1'b0;
         rd_cnt_q    <= '0;
         ext_addr_q  <= `EPROM_EXT_BASE;
      end else if (rd_active_q) begin
         if (rd_last && !pend_q) begin
            rd_active_q <= 1'b0;
            rd_cnt_q    <= '0;
            ext_addr_q  <= ext_addr_q + 24'h1;
         end else if (!rd_last) begin
            rd_cnt_q <= rd_cnt_q + 3'h1;
         end
      end else if (state_q == ST_LOAD && type_q == BT_EPROM && ext_cnt_q != 12'h0 && !pend_d
                   && bus_master) begin
         rd_active_q <= 1'b1;
      end
   end

   // ****************************************************************
   // Transfer counters, sequencing and completion
   // ****************************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_q    <= ST_SAMPLE;
         words_q    <= '0;
         ext_cnt_q  <= '0;
         int_addr_q <= `BOOT_INT_BASE;
      end else begin
         case (state_q)
            ST_SAMPLE: begin
               if (samp_cnt_q == `STRAP_SYNC_CYCLES) begin
                  state_q   <= (type_q == BT_NONE) ? ST_RUN : ST_LOAD;
                  words_q   <= `BOOT_KERNEL_WORDS;
                  ext_cnt_q <= (type_q == BT_EPROM) ? `EPROM_BYTE_COUNT : 12'h0;
               end
            end
            ST_LOAD: begin
               if (take && type_q == BT_EPROM) begin
                  ext_cnt_q <= ext_cnt_q - 12'h1;
               end
               if (push) begin
                  words_q    <= words_q - 9'h1;
                  int_addr_q <= int_addr_q + 24'h1;
               end
               if (words_q == 9'h0 && ext_cnt_q == 12'h0) begin
                  state_q <= ST_FLUSH;
               end
            end
            ST_FLUSH: begin
               if (!mem_wr_valid) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               state_q <= ST_RUN;
            end
            default: begin
               state_q <= ST_SAMPLE;
            end
         endcase
      end
   end

   boot_word_buffer #(.W(72)) u_buf (
      .mclk      (mclk),
      .nrst      (nrst),
      .in_valid  (pend_q),
      .in_ready  (buf_ready),
      .in_data   ({int_addr_q, acc_q}),
      .out_valid (mem_wr_valid),
      .out_ready (mem_wr_ready),
      .out_data  ({mem_wr_addr, mem_wr_data})
   );

   // Outputs toward the core and pins.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         boot_memory_select_out  <= 1'b1;
         boot_memory_select_oe_n <= 1'b1;
         boot_dma_done_interrupt <= 1'b0;
         core_start              <= 1'b0;
         core_start_vector       <= '0;
         dma_channel             <= '0;
         link_rx_buffer          <= '0;
         boot_type               <= BT_NONE;
      end else begin
         boot_type               <= type_q;
         boot_memory_select_out  <= !(state_q == ST_LOAD && type_q == BT_EPROM);
         boot_memory_select_oe_n <= !(state_q == ST_LOAD && type_q == BT_EPROM && bus_master);
         boot_dma_done_interrupt <= state_q == ST_FLUSH && !mem_wr_valid;
         if (state_q == ST_RUN) begin
            core_start        <= 1'b1;
            core_start_vector <= (type_q == BT_NONE) ? NOBOOT_VECTOR : `BOOT_DONE_VECTOR;
         end
         case (type_q)
            BT_SPI:  dma_channel <= `DMA_CH_SPI;
            BT_LINK: dma_channel <= `DMA_CH_LINK;
            BT_NONE: dma_channel <= 4'h0;
            default: dma_channel <= `DMA_CH_EXT_PORT;
         endcase
         link_rx_buffer <= (type_q == BT_LINK) ? `LINK_BOOT_BUFFER : 3'h0;
      end
   end

   assign ext_addr = ext_addr_q;
   assign ext_rd_n = !rd_active_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   property p_type_stable;
      state_q != ST_SAMPLE |-> $stable(type_q);
   endproperty
   a_type_stable: assert property (p_type_stable) else $error("boot type changed after sampling");

   property p_eprom_select;
      state_q == ST_LOAD && type_q == BT_EPROM |=> !boot_memory_select_out;
   endproperty
   a_eprom_select: assert property (p_eprom_select) else $error("select not asserted in EPROM load");

   property p_select_input;
      type_q != BT_EPROM |=> boot_memory_select_oe_n;
   endproperty
   a_select_input: assert property (p_select_input) else $error("select driven outside EPROM mode");

   property p_select_master;
      !boot_memory_select_oe_n |-> $past(bus_master);
   endproperty
   a_select_master: assert property (p_select_master) else $error("select driven without bus");

   property p_strobe_len;
      $fell(ext_rd_n) |-> !ext_rd_n [*8];
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("read strobe shorter than eight cycles");

   property p_addr_step;
      $rose(ext_rd_n) |-> ext_addr == $past(ext_addr) + 24'h1;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("address did not step after read");

   property p_addr_range;
      mem_wr_valid |-> mem_wr_addr >= `BOOT_INT_BASE && mem_wr_addr <= `BOOT_INT_LAST;
   endproperty
   a_addr_range: assert property (p_addr_range) else $error("write outside kernel area");

   property p_spi_channel;
      state_q == ST_LOAD && type_q == BT_SPI |-> dma_channel == `DMA_CH_SPI;
   endproperty
   a_spi_channel: assert property (p_spi_channel) else $error("SPI boot not on channel 8");

   property p_done_vector;
      boot_dma_done_interrupt |-> ##[1:2] core_start && core_start_vector == `BOOT_DONE_VECTOR;
   endproperty
   a_done_vector: assert property (p_done_vector) else $error("no start at completion vector");

   property p_no_early_start;
      state_q == ST_LOAD |-> !core_start;
   endproperty
   a_no_early_start: assert property (p_no_early_start) else $error("core started during load");

   property p_word_count;
      push && words_q == 9'h1 |=> words_q == 9'h0 && int_addr_q == `BOOT_INT_LAST + 24'h1;
   endproperty
   a_word_count: assert property (p_word_count) else $error("kernel length not 256 words");

   c_eprom: cover property (boot_dma_done_interrupt && type_q == BT_EPROM);
   c_host16: cover property (boot_dma_done_interrupt && type_q == BT_HOST && wide_q);
   c_link: cover property (boot_dma_done_interrupt && type_q == BT_LINK);
   c_stall: cover property (mem_wr_valid && !mem_wr_ready && !buf_ready);
endmodule

/* tb/boot_eprom_model.sv */
// Purpose: Byte-wide boot memory behind the select pin and read strobe.
// Assumes: Select and strobe active low; data settles two cycles into a strobe.
// Notes:   Outside a selected read the data pins show the inverse of the last value.
`timescale 1ns/10ps
module boot_eprom_model (
   input  wire logic        mclk,  // Core clock.
   input  wire logic        sel_n, // Chip select pin level.
   input  wire logic        rd_n,  // Output enable.
   input  wire logic [23:0] addr,  // Byte address.
   output logic [7:0]       data   // Data pins.
);
   // ******************************
   // Boot image and read timing
   // ******************************
   int lat = 0;

   // The shifted term makes neighbouring words differ, so a slip in packing shows.
   function automatic logic [7:0] pat(input int i);
      return 8'(i) ^ 8'(i >> 5);
   endfunction

   initial data = 8'h00;

   always @(posedge mclk) begin
      if (!sel_n && !rd_n) begin
         lat <= lat + 1;
         data <= (lat >= 1) ? pat(int'(addr - 24'h800000)) : ~data;
      end else begin
         lat <= 0;
         data <= ~data;
      end
   end
endmodule

/* tb/power_up_boot_mode_loader_tb_top.sv */
// Purpose: Self-checking bench of the boot loader in every boot type.
// Assumes: Defines header and package compiled first; one clock domain.
// Notes:   One source drives all three unit ports, so a port of the wrong mode must stay idle.
`timescale 1ns/10ps
`include "boot_loader_defines.svh"
module power_up_boot_mode_loader_tb_top
   import boot_loader_pkg::*;
;
   // ******************************
   // Stimulus, partner and sink
   // ******************************
   localparam logic [23:0] NV = 24'h2a0000;
   logic mclk = 1'b0, nrst, eprom_boot_strap, link_boot_strap, host_bus_16bit, sel_strap, bus_master;
   logic host_valid, link_valid, spi_rx_valid, mem_wr_ready = 1'b0;
   logic [15:0] host_data;
   logic [3:0] link_nibble, dma_channel;
   logic [7:0] spi_rx_byte, ext_data;
   logic boot_memory_select_out, boot_memory_select_oe_n, ext_rd_n, host_ready, link_ready, spi_rx_ready;
   logic mem_wr_valid, boot_dma_done_interrupt, core_start;
   logic [23:0] ext_addr, mem_wr_addr, core_start_vector;
   logic [47:0] mem_wr_data;
   logic [2:0] link_rx_buffer;
   logic [5:0] cyc = 6'h00;
   boot_type_t boot_type;
   wire logic boot_memory_select_in;
   int fails = 0, checks = 0, widx = 0;

   // The pin is the driven level while enabled, else the board strap.
   assign boot_memory_select_in = !boot_memory_select_oe_n ? boot_memory_select_out : sel_strap;

   always #5 mclk = ~mclk;

   power_up_boot_mode_loader #(.NOBOOT_VECTOR(NV)) dut_u (.mclk, .nrst, .eprom_boot_strap, .link_boot_strap,
      .host_bus_16bit, .boot_memory_select_in, .boot_memory_select_out, .boot_memory_select_oe_n, .bus_master,
      .ext_addr, .ext_rd_n, .ext_data, .host_valid, .host_data, .host_ready, .link_valid, .link_nibble,
      .link_ready, .link_rx_buffer, .spi_rx_valid, .spi_rx_byte, .spi_rx_ready, .mem_wr_valid, .mem_wr_addr,
      .mem_wr_data, .mem_wr_ready, .boot_type, .dma_channel, .boot_dma_done_interrupt, .core_start,
      .core_start_vector);

   boot_eprom_model eprom_u (.mclk(mclk), .sel_n(boot_memory_select_in), .rd_n(ext_rd_n), .addr(ext_addr),
      .data(ext_data));

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [47:0] word_of(input int n);
      for (int k = 0; k < 6; k++) word_of[8*k +: 8] = eprom_u.pat(6 * n + k);
   endfunction

   // Sink stalls 16 of every 64 cycles so the two-entry buffer fills.
   always @(posedge mclk) begin
      cyc <= cyc + 6'h01;
      mem_wr_ready <= (cyc[5:4] != 2'h3);
      if (!nrst) widx <= 0;
      else if (mem_wr_valid && mem_wr_ready) begin
         chk(mem_wr_addr, `BOOT_INT_BASE + 24'(widx));
         chk(mem_wr_data, word_of(widx));
         widx <= widx + 1;
      end
   end

   // ******************************
   // Scenarios
   // ******************************
   // Straps p = {eprom, link, select, host width}; eprom, link and host width are turned round after decode.
   task automatic boot(input logic [3:0] p, input boot_type_t t, input logic [3:0] ch);
      nrst <= 1'b0;
      {eprom_boot_strap, link_boot_strap, sel_strap, host_bus_16bit} <= p;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      repeat (6) @(posedge mclk);
      {eprom_boot_strap, link_boot_strap, host_bus_16bit} <= ~{p[3:2], p[0]};
      repeat (4) @(posedge mclk);
      chk(boot_type, t);
      chk(dma_channel, ch);
      chk(link_rx_buffer, (t == BT_LINK) ? 3'h4 : 3'h0);
      chk(core_start, t == BT_NONE);
   endtask

   task automatic feed(input int w);
      int b;
      for (int u = 0; u < 256 * 48 / w; u++) begin
         b = u * w;
         {host_valid, link_valid, spi_rx_valid} <= 3'h7;
         host_data <= {eprom_u.pat(b / 8 + 1), eprom_u.pat(b / 8)} >> (b % 8);
         link_nibble <= 4'(eprom_u.pat(b / 8) >> (b % 8));
         spi_rx_byte <= eprom_u.pat(b / 8);
         @(posedge mclk);
         while (!(host_ready || link_ready || spi_rx_ready)) @(posedge mclk);
      end
      {host_valid, link_valid, spi_rx_valid} <= 3'h0;
   endtask

   task automatic finish_load();
      for (int t = 0; t < 30000 && boot_dma_done_interrupt !== 1'b1; t++) @(posedge mclk);
      chk(boot_dma_done_interrupt, 1'b1);
      chk(widx, 256);
      chk(core_start, 1'b0);
      chk(boot_memory_select_oe_n, 1'b1);
      @(posedge mclk);
      chk(boot_dma_done_interrupt, 1'b0);
      chk({core_start, core_start_vector}, {1'b1, `BOOT_DONE_VECTOR});
   endtask

   task automatic t_noboot();
      boot(4'b0000, BT_NONE, 4'h0);
      chk({core_start_vector, boot_memory_select_oe_n}, {NV, 1'b1});
      boot(4'b1110, BT_NONE, 4'h0);
   endtask

   task automatic t_spi();
      boot(4'b0100, BT_SPI, `DMA_CH_SPI);
      chk(boot_memory_select_oe_n, 1'b1);
      feed(8);
      finish_load();
      spi_rx_valid <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(spi_rx_ready, 1'b0);
      spi_rx_valid <= 1'b0;
   endtask

   task automatic t_host(input logic wide);
      boot({3'b001, wide}, BT_HOST, 4'ha);
      chk(boot_memory_select_oe_n, 1'b1);
      feed(wide ? 16 : 8);
      finish_load();
   endtask

   task automatic t_link();
      boot(4'b0110, BT_LINK, `DMA_CH_LINK);
      feed(4);
      finish_load();
   endtask

   task automatic t_eprom();
      int n;
      bus_master <= 1'b0;
      boot(4'b1010, BT_EPROM, 4'ha);
      chk({boot_memory_select_oe_n, ext_rd_n}, 2'h3);
      bus_master <= 1'b1;
      for (n = 0; n < 40 && ext_rd_n !== 1'b0; n++) @(posedge mclk);
      chk({ext_addr, boot_memory_select_out, boot_memory_select_oe_n}, {`EPROM_EXT_BASE, 2'h0});
      for (n = 0; n < 20 && ext_rd_n === 1'b0; n++) @(posedge mclk);
      chk(n, 8);
      chk(ext_addr, `EPROM_EXT_BASE + 24'h1);
      finish_load();
   endtask

   task automatic tally_and_finish();
      if (fails == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      #500000;
      fails++;
      tally_and_finish();
   end

   initial begin
      {nrst, eprom_boot_strap, link_boot_strap, host_bus_16bit, sel_strap, bus_master} = 6'h01;
      {host_valid, link_valid, spi_rx_valid, host_data, link_nibble, spi_rx_byte} = '0;
      t_noboot();
      t_spi();
      t_host(1'b1);
      t_host(1'b0);
      t_link();
      t_eprom();
      tally_and_finish();
   end
endmodule
